// >>> shared/tcw_defs.svh
// constants for the tick counter / watchdog / shared divider block
`ifndef TCW_DEFS_SVH
`define TCW_DEFS_SVH

// =====================================================================
// option bit positions
`define TCW_OPT_RATIO_LSB 0
`define TCW_OPT_RATIO_MSB 2
`define TCW_OPT_ASSIGN 3
`define TCW_OPT_EDGE 4
`define TCW_OPT_SOURCE 5
`define TCW_OPT_IRQ_EN 6

// =====================================================================
// reset values and counter top value
`define TCW_OPT_RESET 8'h0e
`define TCW_ZERO8 8'h00
`define TCW_MAX8 8'hff

// =====================================================================
// watchdog clock figures
`define TCW_WD_CLK_HZ 16000
`define TCW_SYS_CLK_HZ 100000000

`endif

// >>> shared/tcw_pkg.sv
// types for the tick counter / watchdog / shared divider block
`default_nettype none
package tcw_pkg;
	typedef enum logic {
		TCW_DIV_TO_TICK,
		TCW_DIV_TO_WATCHDOG
	} tcw_assign_e;
endpackage
`default_nettype wire

// >>> hw/tcw_edge_detect.sv
// external count pin sampler and edge qualifier
`timescale 1ns/1ps
`default_nettype none
`include "tcw_defs.svh"

module tcw_edge_detect
	import tcw_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// pin and edge select
	input wire logic pin,
	input wire logic falling_sel,
	// qualified transition
	output logic edge_pulse
);
	logic sample_reg;
	logic prev_reg;
	logic [1:0] fill_reg;

	// =====================================================================
	// sampling
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sample_reg <= 1'b0;
			prev_reg <= 1'b0;
			fill_reg <= '0;
		end else begin
			sample_reg <= pin;
			prev_reg <= sample_reg;
			fill_reg <= {fill_reg[0], 1'b1};
		end
	end

	// pin idle level is unknown at reset: no edge until two real samples are held
	logic primed;
	assign primed = fill_reg[1];

	// pin must toggle below half the clock rate or edges merge
	assign edge_pulse = primed & (falling_sel ? (prev_reg & ~sample_reg)
		: (~prev_reg & sample_reg));
endmodule
`default_nettype wire

// >>> hw/tcw_divider.sv
// shared 8-bit programmable divider
`timescale 1ns/1ps
`default_nettype none
`include "tcw_defs.svh"

module tcw_divider
	import tcw_pkg::*;
#(
	parameter int WIDTH = 8
)(
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// control
	input wire logic clear,
	input wire logic step,
	input wire logic [2:0] ratio,
	// output tick
	output logic tick
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic [WIDTH-1:0] mask;

	// =====================================================================
	// ratio 000 -> 1:2 ... 111 -> 1:256
	assign mask = WIDTH'((9'h002 << ratio) - 9'h001);
	assign count_next = count_reg + WIDTH'(1);
	assign tick = step & ((count_reg & mask) == mask);

	// count is private: no read or write path to the core
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
		end else if (clear) begin
			count_reg <= '0;
		end else if (step) begin
			count_reg <= count_next;
		end
	end
endmodule
`default_nettype wire

// >>> hw/tcw_top.sv
// tick counter and watchdog sharing one programmable divider
// Functional notes
// - 8-bit tick counter, internal or external events
// - divider ahead of counter extends range
// - option bit 5 selects external pin source
// - internal source: every cycle, or divider ticks
// - external pin sampled every rising clock edge
// - option bit 4 one selects falling edge
// - wrap FFh to 00h sets rollover pending
// - counter write clears divider when prescaling
// - 8-bit watchdog on slow 16 kHz clock
// - timeout resets only when config enable set
// - reset default: watchdog, ratio 1:128
// - option bit 3 assigns divider, never both
// - ratio field applies to assigned counter
// - divider count hidden from processor
// - rollover interrupt has own enable bit
`timescale 1ns/1ps
`default_nettype none
`include "tcw_defs.svh"

module tcw_top
	import tcw_pkg::*;
#(
	parameter int WD_CLK_HZ = `TCW_WD_CLK_HZ,
	parameter int SYS_CLK_HZ = `TCW_SYS_CLK_HZ,
	parameter int WD_TICK_CYCLES = SYS_CLK_HZ / WD_CLK_HZ
)(
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// option register
	input wire logic option_write,
	input wire logic [7:0] option_wdata,
	output logic [7:0] option_value,
	// tick counter access
	input wire logic tick_write,
	input wire logic [7:0] tick_wdata,
	output logic [7:0] tick_counter,
	// core events
	input wire logic instruction_cycle,
	input wire logic watchdog_clear_instruction,
	input wire logic pending_clear,
	// external count pin
	input wire logic tick_pin,
	// configuration word
	input wire logic watchdog_enable_cfg,
	// status and events
	output logic tick_rollover_pending,
	output logic tick_irq,
	output logic [7:0] watchdog_counter,
	output logic watchdog_reset
);
	logic [7:0] option_reg;
	logic [7:0] tick_reg;
	logic [7:0] wd_reg;
	logic pending_reg;
	logic wd_reset_reg;
	logic [31:0] osc_cnt_reg;
	logic wd_osc_tick;
	logic ext_edge;
	logic tick_event;
	logic tick_step;
	logic div_step;
	logic div_tick;
	logic div_clear;
	logic wd_step;
	logic wrap;
	tcw_assign_e assign_sel;

	// =====================================================================
	// option register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			option_reg <= `TCW_OPT_RESET;
		end else if (option_write) begin
			option_reg <= option_wdata;
		end
	end
	assign option_value = option_reg;
	assign assign_sel = option_reg[`TCW_OPT_ASSIGN] ? TCW_DIV_TO_WATCHDOG : TCW_DIV_TO_TICK;

	// =====================================================================
	// event sources
	tcw_edge_detect u_edge (
		.clock(clock),
		.arst_n(arst_n),
		.pin(tick_pin),
		.falling_sel(option_reg[`TCW_OPT_EDGE]),
		.edge_pulse(ext_edge)
	);

	assign tick_event = option_reg[`TCW_OPT_SOURCE] ? ext_edge : instruction_cycle;

	// free-running stand-in for the slow watchdog oscillator
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			osc_cnt_reg <= '0;
		end else if (osc_cnt_reg >= 32'(WD_TICK_CYCLES - 1)) begin
			osc_cnt_reg <= '0;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 32'h1;
		end
	end
	assign wd_osc_tick = (osc_cnt_reg >= 32'(WD_TICK_CYCLES - 1));

	// =====================================================================
	// divider routing: one user at a time
	always_comb begin
		unique case (assign_sel)
			TCW_DIV_TO_TICK: begin
				div_step = tick_event;
				tick_step = div_tick;
				wd_step = wd_osc_tick;
				div_clear = tick_write;
			end
			TCW_DIV_TO_WATCHDOG: begin
				div_step = wd_reg == `TCW_MAX8 && wd_osc_tick;
				tick_step = tick_event;
				wd_step = wd_osc_tick;
				div_clear = watchdog_clear_instruction;
			end
		endcase
	end

	tcw_divider #(
		.WIDTH(8)
	) u_div (
		.clock(clock),
		.arst_n(arst_n),
		.clear(div_clear),
		.step(div_step),
		.ratio(option_reg[`TCW_OPT_RATIO_MSB:`TCW_OPT_RATIO_LSB]),
		.tick(div_tick)
	);

	// =====================================================================
	// tick counter
	assign wrap = tick_step && !tick_write && tick_reg == `TCW_MAX8;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tick_reg <= `TCW_ZERO8;
		end else if (tick_write) begin
			tick_reg <= tick_wdata;
		end else if (tick_step) begin
			tick_reg <= tick_reg + 8'h01;
		end
	end
	assign tick_counter = tick_reg;

	// set wins over a same-cycle clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pending_reg <= 1'b0;
		end else if (wrap) begin
			pending_reg <= 1'b1;
		end else if (pending_clear) begin
			pending_reg <= 1'b0;
		end
	end
	assign tick_rollover_pending = pending_reg;
	assign tick_irq = pending_reg & option_reg[`TCW_OPT_IRQ_EN];

	// =====================================================================
	// watchdog
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wd_reg <= `TCW_ZERO8;
		end else if (watchdog_clear_instruction) begin
			wd_reg <= `TCW_ZERO8;
		end else if (wd_step) begin
			wd_reg <= wd_reg + 8'h01;
		end
	end
	assign watchdog_counter = wd_reg;

	// timeout: wrap of watchdog, through divider when assigned there
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wd_reset_reg <= 1'b0;
		end else begin
			wd_reset_reg <= watchdog_enable_cfg && !watchdog_clear_instruction &&
				((assign_sel == TCW_DIV_TO_WATCHDOG) ? div_tick
					: (wd_step && wd_reg == `TCW_MAX8));
		end
	end
	assign watchdog_reset = wd_reset_reg;
endmodule
`default_nettype wire

// >>> bench/tcw_top_asserts.sv
// checker for the tick counter / watchdog block
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// assertions on the top ports
module tcw_top_asserts import tcw_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// option register
	input wire logic option_write,
	input wire logic [7:0] option_wdata,
	input wire logic [7:0] option_value,
	// tick counter access
	input wire logic tick_write,
	input wire logic [7:0] tick_wdata,
	input wire logic [7:0] tick_counter,
	// core events
	input wire logic instruction_cycle,
	input wire logic watchdog_clear_instruction,
	input wire logic pending_clear,
	// external pin and configuration
	input wire logic tick_pin,
	input wire logic watchdog_enable_cfg,
	// status and events
	input wire logic tick_rollover_pending,
	input wire logic tick_irq,
	input wire logic [7:0] watchdog_counter,
	input wire logic watchdog_reset
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// internal source, no divider, no load this cycle
	wire logic quiet = !tick_write && !option_write;
	wire logic plain = quiet && option_value[5:3] == 3'b001;
	sequence s_wrap; quiet && tick_counter == 8'hff ##1 tick_counter == 8'h00; endsequence
	sequence s_rise; !tick_write && option_value[5:3] == 3'b101 && $rose(tick_pin); endsequence
	property p_write; tick_write |=> tick_counter == $past(tick_wdata); endproperty
	a_write: assert property (p_write) else $error("bad load");
	property p_inc;
		plain && instruction_cycle |=> tick_counter == $past(tick_counter) + 8'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("bad step");
	property p_idle; plain && !instruction_cycle |=> $stable(tick_counter); endproperty
	a_idle: assert property (p_idle) else $error("stray step");
	property p_pin; s_rise |-> ##[2:4] $changed(tick_counter); endproperty
	a_pin: assert property (p_pin) else $error("pin edge lost");
	property p_wrap; s_wrap |-> tick_rollover_pending; endproperty
	a_wrap: assert property (p_wrap) else $error("no pending");
	// no wrap is possible unless the counter stands at its top value
	property p_pclr; pending_clear && tick_counter != 8'hff |=> !tick_rollover_pending; endproperty
	a_pclr: assert property (p_pclr) else $error("pending not cleared");
	property p_irq; tick_irq == (tick_rollover_pending && option_value[6]); endproperty
	a_irq: assert property (p_irq) else $error("bad irq");
	property p_opt; option_write |=> option_value == $past(option_wdata); endproperty
	a_opt: assert property (p_opt) else $error("bad option");
	property p_wdclr; watchdog_clear_instruction |=> watchdog_counter == 8'h00; endproperty
	a_wdclr: assert property (p_wdclr) else $error("bad clear");
	property p_wdoff; !watchdog_enable_cfg && !$past(watchdog_enable_cfg) |-> !watchdog_reset;
	endproperty
	a_wdoff: assert property (p_wdoff) else $error("reset while off");
endmodule
bind tcw_top tcw_top_asserts i_chk (.clock, .arst_n, .option_write, .tick_write,
	.instruction_cycle, .watchdog_clear_instruction, .pending_clear, .tick_pin,
	.watchdog_enable_cfg,
	.option_wdata, .tick_wdata, .option_value, .tick_counter, .watchdog_counter,
	.tick_rollover_pending, .tick_irq, .watchdog_reset);
`default_nettype wire

// >>> bench/tcw_pin_model.sv
// external count pin source
`timescale 1ns/1ps
`default_nettype none
// ====
module tcw_pin_model import tcw_pkg::*; (
	// control
	input wire logic clock,
	input wire logic run,
	// pin
	output logic tick_pin
);
	int phase = 0;
	logic pin_reg = 1'b0;
	assign tick_pin = pin_reg;
	// three cycles a level keeps every edge visible to the sampler
	always @(negedge clock) begin
		if (run) begin
			phase = (phase + 1) % 3;
			if (phase == 0) pin_reg <= !pin_reg;
		end
	end
endmodule
`default_nettype wire

// >>> bench/tick_counter_watchdog_prescaler_test.sv
// self-checking bench for the tick counter / watchdog block
`timescale 1ns/1ps
`default_nettype none
// ====
module tick_counter_watchdog_prescaler_test import tcw_pkg::*; ;
	logic clock = 0, arst_n = 0, option_write = 0, tick_write = 0, instruction_cycle = 0;
	logic watchdog_clear_instruction = 0, pending_clear = 0, watchdog_enable_cfg = 0;
	logic run = 0, take = 0, span_ok = 0, tick_pin, tick_rollover_pending, tick_irq;
	logic watchdog_reset;
	logic [7:0] option_wdata = 0, tick_wdata = 0, option_value, tick_counter, watchdog_counter;
	logic [7:0] v;
	logic [15:0] nt;
	logic [15:0] notes[$];
	int seed = 24003, failures = 0, cmp_count = 0, n, rises, falls, span;
	localparam int WD_CYC = 4;
	string nm[6] = '{"counter", "option", "pending", "irq", "wdog", "span"};
	wire logic [47:0] obs = {7'h00, span_ok, watchdog_counter, 7'h00, tick_irq, 7'h00,
		tick_rollover_pending, option_value, tick_counter};
	tcw_top #(.WD_TICK_CYCLES(WD_CYC)) i_dut (.clock, .arst_n, .option_write, .option_wdata,
		.option_value, .tick_write, .tick_wdata, .tick_counter, .instruction_cycle,
		.watchdog_clear_instruction, .pending_clear, .tick_pin, .watchdog_enable_cfg,
		.tick_rollover_pending, .tick_irq, .watchdog_counter, .watchdog_reset);
	tcw_pin_model i_pin (.clock, .run, .tick_pin);
	always #5 clock = !clock;
	always @(posedge tick_pin) rises++;
	always @(negedge tick_pin) falls++;
	// ====
	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// note is sampled at the next rising edge, before that edge's updates land
	task automatic note(input logic [7:0] s, input logic [7:0] e);
		notes.push_back({s, e});
		take <= 1'b1;
		@(negedge clock);
		take <= 1'b0;
		@(negedge clock);
	endtask
	task automatic wr_opt(input logic [7:0] d);
		option_wdata <= d;
		option_write <= 1'b1;
		cyc(1);
		option_write <= 1'b0;
	endtask
	task automatic wr_tick(input logic [7:0] d);
		tick_wdata <= d;
		tick_write <= 1'b1;
		cyc(1);
		tick_write <= 1'b0;
	endtask
	task automatic inst(input int k);
		instruction_cycle <= 1'b1;
		cyc(k);
		instruction_cycle <= 1'b0;
	endtask
	// ====
	task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic cmp_flag(input string what, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %b got %b", what, e, g);
		end
	endtask
	always @(posedge clock) begin
		if (take) begin
			nt = notes.pop_front();
			if (nt[15:8] == 8'h02 || nt[15:8] == 8'h03 || nt[15:8] == 8'h05) begin
				cmp_flag(nm[nt[15:8]], nt[0], obs[nt[15:8] * 8]);
			end else begin
				cmp_byte(nm[nt[15:8]], nt[7:0], obs[nt[15:8] * 8 +: 8]);
			end
		end
	end
	initial begin
		#100000;
		failures++;
		test_done();
	end
	initial begin
		cyc(2);
		arst_n <= 1'b1;
		cyc(1);
		note(1, 8'h0e);
		wr_opt(8'h08);
		v = 8'($random(seed));
		n = ($random(seed) & 15) + 1;
		wr_tick(v);
		inst(n);
		note(0, v + n[7:0]);
		wr_tick(8'hfe);
		inst(2);
		note(2, 8'h01);
		wr_opt(8'h48);
		note(3, 8'h01);
		pending_clear <= 1'b1;
		cyc(1);
		pending_clear <= 1'b0;
		note(3, 8'h00);
		$display("internal test done");
		for (int r = 0; r < 8; r++) begin
			wr_opt(r[7:0]);
			inst(5);
			wr_tick(8'h00);
			inst((3 << (r + 1)) - 1);
			note(0, 8'h02);
		end
		$display("divider test done");
		for (int e = 0; e < 2; e++) begin
			wr_opt(e ? 8'h38 : 8'h28);
			wr_tick(8'h00);
			rises = 0;
			falls = 0;
			run <= 1'b1;
			cyc(60);
			run <= 1'b0;
			cyc(6);
			note(0, e ? falls[7:0] : rises[7:0]);
		end
		$display("pin test done");
		for (int w = 0; w < 2; w++) begin
			wr_opt(w ? 8'h08 : 8'h00);
			watchdog_enable_cfg <= 1'b1;
			watchdog_clear_instruction <= 1'b1;
			cyc(1);
			watchdog_clear_instruction <= 1'b0;
			note(4, 8'h00);
			span = 0;
			while (watchdog_reset !== 1'b1 && span < 3000) begin
				cyc(1);
				span++;
			end
			// 256 watchdog steps, doubled by a 1:2 postscaler
			span_ok = span > 256 * WD_CYC * (w + 1) - 10 && span < 256 * WD_CYC * (w + 1) + 10;
			note(5, 8'h01);
		end
		$display("watchdog test done");
		test_done();
	end
endmodule
`default_nettype wire
